// ### logic/cssse_exec.sv
// four-phase execution unit for compare-and-skip, sleep and subtract-with-borrow
// Function
// - compare greater: file minus accumulator, flags untouched, skip next when file greater.
// - compare less: skip next instruction as a no-op when file below accumulator.
// - compares take one cycle, two when skipping, three over a two-word instruction.
// - access bit 0 picks access bank; 1 picks bank select register bank.
// - sleep clears watchdog, sets timeout flag, clears power-down flag, halts the core.
// - subtract accumulator minus file minus borrow, set five flags, write acc or file.
`timescale 1ns/1ns
module cssse_exec (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // instruction stream and core context
  input wire logic [15:0] INSTR_I,
  input wire logic WAKE_I,
  input wire logic [3:0] BANK_SELECT_REG_I,
  input cssse_pkg::cssse_preset_s PRESET_I,
  // file register port
  output cssse_pkg::cssse_file_req_s FILE_REQ_O,
  input wire logic [7:0] FILE_RDATA_I,
  // core state
  output logic [3:0] PHASE_O,
  output logic SKIPPING_O,
  output logic [7:0] WORKING_ACCUMULATOR_O,
  output cssse_pkg::cssse_flags_s FLAGS_O,
  // power management
  output logic TIMEOUT_FLAG_O,
  output logic POWER_DOWN_FLAG_O,
  output logic WATCHDOG_CLEAR_O,
  output logic SLEEP_O
);
  import cssse_pkg::*;

  // ==========================================================================
  // state
  cssse_phase_e phase_r, phase_nxt;
  cssse_kind_e kind_r, kind_nxt;
  logic dest_file_r, dest_file_nxt;
  logic skip_r, skip_nxt;
  logic nop_r, nop_nxt;
  logic [7:0] operand_r, operand_nxt;
  logic [7:0] result_r, result_nxt;
  cssse_flags_s res_flags_r, res_flags_nxt;
  cssse_file_req_s file_req_r, file_req_nxt;
  logic [7:0] acc_r, acc_nxt;
  cssse_flags_s flags_r, flags_nxt;
  logic timeout_r, timeout_nxt;
  logic power_down_r, power_down_nxt;
  logic wdt_clear_r, wdt_clear_nxt;
  logic sleep_r, sleep_nxt;

  logic [7:0] alu_diff;
  cssse_flags_s alu_flags;
  logic alu_gt;
  logic alu_lt;

  // ==========================================================================
  // helpers
  function automatic logic is_two_word(input logic [15:0] word);
    is_two_word = (word[15:12] == TWO_WORD_MOVE_OPC) ||
                  (word[15:9] == TWO_WORD_CALL_OPC) ||
                  (word[15:8] == TWO_WORD_LOAD_PTR_OPC) ||
                  (word[15:8] == TWO_WORD_JUMP_OPC);
  endfunction : is_two_word

  function automatic cssse_kind_e decode(input logic [15:0] word);
    if (word[15:9] == CMP_GT_OPC) begin
      decode = K_GT;
    end else if (word[15:9] == CMP_LT_OPC) begin
      decode = K_LT;
    end else if (word[15:10] == SUB_BORROW_OPC) begin
      decode = K_SUB;
    end else if (word == SLEEP_WORD) begin
      decode = K_SLEEP;
    end else begin
      decode = K_NOP;
    end
  endfunction : decode

  function automatic logic [11:0] file_address(input logic [15:0] word, input logic [3:0] bank);
    if (word[ACCESS_BIT]) begin
      file_address = {bank, word[7:0]};
    end else if (word[7:0] < ACCESS_SPLIT) begin
      file_address = {ACCESS_LOW_BANK, word[7:0]};
    end else begin
      file_address = {ACCESS_HIGH_BANK, word[7:0]};
    end
  endfunction : file_address

  // ==========================================================================
  // datapath
  cssse_alu u_alu (
    .acc_i(acc_r),
    .file_i(operand_r),
    .carry_i(flags_r.c),
    .diff_o(alu_diff),
    .flags_o(alu_flags),
    .gt_o(alu_gt),
    .lt_o(alu_lt)
  );

  // ==========================================================================
  // phase sequencer and execution
  always_comb begin
    phase_nxt = phase_r;
    kind_nxt = kind_r;
    dest_file_nxt = dest_file_r;
    skip_nxt = skip_r;
    nop_nxt = nop_r;
    operand_nxt = operand_r;
    result_nxt = result_r;
    res_flags_nxt = res_flags_r;
    file_req_nxt = file_req_r;
    file_req_nxt.rd = 1'b0;
    file_req_nxt.wr = 1'b0;
    acc_nxt = acc_r;
    flags_nxt = flags_r;
    timeout_nxt = timeout_r;
    power_down_nxt = power_down_r;
    wdt_clear_nxt = 1'b0;
    sleep_nxt = sleep_r;

    // presets from the rest of the core, overridden by write-back below
    if (PRESET_I.acc_load) begin
      acc_nxt = PRESET_I.acc;
    end
    if (PRESET_I.flags_load) begin
      flags_nxt = PRESET_I.flags;
    end

    case (phase_r)
      PH_Q1: begin
        // the halted core holds Q1 and takes no instruction until woken
        if (sleep_r) begin
          if (WAKE_I) begin
            sleep_nxt = 1'b0;
          end
        end else begin
          phase_nxt = PH_Q2;
          file_req_nxt.addr = file_address(INSTR_I, BANK_SELECT_REG_I);
          dest_file_nxt = INSTR_I[DEST_BIT];
          if (skip_r) begin
            // a skipped two-word head keeps skipping over its second word
            kind_nxt = K_NOP;
            nop_nxt = 1'b1;
            skip_nxt = is_two_word(INSTR_I);
          end else begin
            kind_nxt = decode(INSTR_I);
            nop_nxt = 1'b0;
            skip_nxt = 1'b0;
            file_req_nxt.rd = (decode(INSTR_I) == K_GT) || (decode(INSTR_I) == K_LT) ||
                              (decode(INSTR_I) == K_SUB);
          end
        end
      end
      PH_Q2: begin
        phase_nxt = PH_Q3;
        if (file_req_r.rd) begin
          operand_nxt = FILE_RDATA_I;
        end
      end
      PH_Q3: begin
        phase_nxt = PH_Q4;
        case (kind_r)
          K_GT: begin
            skip_nxt = alu_gt;
          end
          K_LT: begin
            skip_nxt = alu_lt;
          end
          K_SUB: begin
            result_nxt = alu_diff;
            res_flags_nxt = alu_flags;
            file_req_nxt.wr = dest_file_r;
            file_req_nxt.wdata = alu_diff;
          end
          default: begin
          end
        endcase
      end
      PH_Q4: begin
        phase_nxt = PH_Q1;
        case (kind_r)
          K_SUB: begin
            flags_nxt = res_flags_r;
            if (!dest_file_r) begin
              acc_nxt = result_r;
            end
          end
          K_SLEEP: begin
            wdt_clear_nxt = 1'b1;
            timeout_nxt = 1'b1;
            power_down_nxt = 1'b0;
            sleep_nxt = 1'b1;
          end
          default: begin
          end
        endcase
      end
      default: begin
        phase_nxt = PH_Q1;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      phase_r <= PH_Q1;
      kind_r <= K_NOP;
      dest_file_r <= 1'b0;
      skip_r <= 1'b0;
      nop_r <= 1'b0;
      operand_r <= 8'h00;
      result_r <= 8'h00;
      res_flags_r <= '0;
      file_req_r <= '0;
      acc_r <= ACC_RST;
      flags_r <= '0;
      timeout_r <= TIMEOUT_FLAG_RST;
      power_down_r <= POWER_DOWN_FLAG_RST;
      wdt_clear_r <= 1'b0;
      sleep_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      kind_r <= kind_nxt;
      dest_file_r <= dest_file_nxt;
      skip_r <= skip_nxt;
      nop_r <= nop_nxt;
      operand_r <= operand_nxt;
      result_r <= result_nxt;
      res_flags_r <= res_flags_nxt;
      file_req_r <= file_req_nxt;
      acc_r <= acc_nxt;
      flags_r <= flags_nxt;
      timeout_r <= timeout_nxt;
      power_down_r <= power_down_nxt;
      wdt_clear_r <= wdt_clear_nxt;
      sleep_r <= sleep_nxt;
    end
  end

  // ==========================================================================
  // outputs, all straight from flip-flops
  always_comb begin
    FILE_REQ_O = file_req_r;
    PHASE_O = phase_r;
    SKIPPING_O = nop_r;
    WORKING_ACCUMULATOR_O = acc_r;
    FLAGS_O = flags_r;
    TIMEOUT_FLAG_O = timeout_r;
    POWER_DOWN_FLAG_O = power_down_r;
    WATCHDOG_CLEAR_O = wdt_clear_r;
    SLEEP_O = sleep_r;
  end

endmodule : cssse_exec

// ### include/cssse_pkg.sv
// shared constants and types for the compare/skip/sleep/subtract execution unit
package cssse_pkg;

  // ==========================================================================
  // instruction encodings
  localparam logic [6:0] CMP_GT_OPC = 7'h32;       // 0110 010a
  localparam logic [6:0] CMP_LT_OPC = 7'h30;       // 0110 000a
  localparam logic [5:0] SUB_BORROW_OPC = 6'h15;   // 0101 01da
  localparam logic [15:0] SLEEP_WORD = 16'h0003;
  // first words of the two-word instructions
  localparam logic [3:0] TWO_WORD_MOVE_OPC = 4'hC;
  localparam logic [6:0] TWO_WORD_CALL_OPC = 7'h76;
  localparam logic [7:0] TWO_WORD_LOAD_PTR_OPC = 8'hEE;
  localparam logic [7:0] TWO_WORD_JUMP_OPC = 8'hEF;

  // ==========================================================================
  // operand field positions
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;

  // ==========================================================================
  // access bank layout
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  // ==========================================================================
  // values after reset
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic TIMEOUT_FLAG_RST = 1'b1;
  localparam logic POWER_DOWN_FLAG_RST = 1'b1;

  // ==========================================================================
  // types
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } cssse_phase_e;

  typedef enum logic [4:0] {
    K_NOP = 5'h01,
    K_GT = 5'h02,
    K_LT = 5'h04,
    K_SUB = 5'h08,
    K_SLEEP = 5'h10
  } cssse_kind_e;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } cssse_flags_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } cssse_file_req_s;

  typedef struct packed {
    logic acc_load;
    logic [7:0] acc;
    logic flags_load;
    cssse_flags_s flags;
  } cssse_preset_s;

endpackage : cssse_pkg

// ### logic/cssse_alu.sv
// subtract-with-borrow datapath and unsigned compare of file operand against accumulator
`timescale 1ns/1ns
module cssse_alu (
  // operands
  input wire logic [7:0] acc_i,
  input wire logic [7:0] file_i,
  input wire logic carry_i,
  // results
  output logic [7:0] diff_o,
  output cssse_pkg::cssse_flags_s flags_o,
  output logic gt_o,
  output logic lt_o
);
  import cssse_pkg::*;

  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // ==========================================================================
  // acc - file - borrow, borrow being the inverted carry
  always_comb begin
    full_sum = {1'b0, acc_i} + {1'b0, ~file_i} + {8'h00, carry_i};
    low_sum = {1'b0, acc_i[3:0]} + {1'b0, ~file_i[3:0]} + {4'h0, carry_i};
    diff_o = full_sum[7:0];
    flags_o.c = full_sum[8];
    flags_o.dc = low_sum[4];
    flags_o.z = (full_sum[7:0] == 8'h00);
    flags_o.n = full_sum[7];
    flags_o.ov = (acc_i[7] != file_i[7]) && (full_sum[7] != acc_i[7]);
  end

  // ==========================================================================
  // compares never touch the flags, so they use a plain unsigned relation
  always_comb begin
    gt_o = (file_i > acc_i);
    lt_o = (file_i < acc_i);
  end

endmodule : cssse_alu

// ### verif/cssse_exec_sva.sv
// assertion checker bound to the execution unit
`timescale 1ns/1ns
module cssse_exec_sva (
  // clock, reset and inputs
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic WAKE_I,
  input wire logic [15:0] INSTR_I,
  input wire logic [3:0] BANK_SELECT_REG_I,
  input cssse_pkg::cssse_preset_s PRESET_I,
  // outputs watched
  input cssse_pkg::cssse_file_req_s FILE_REQ_O,
  input wire logic [3:0] PHASE_O,
  input wire logic SKIPPING_O,
  input cssse_pkg::cssse_flags_s FLAGS_O,
  input wire logic TIMEOUT_FLAG_O,
  input wire logic POWER_DOWN_FLAG_O,
  input wire logic WATCHDOG_CLEAR_O,
  input wire logic SLEEP_O
);
  import cssse_pkg::*;
  logic take;
  logic fl_ld;
  logic sub_q4;
  logic [15:0] ins_r;
  logic [15:0] ins_nxt;
  logic [3:0] bsr_r;
  logic [3:0] bsr_nxt;
  assign take = PHASE_O == 4'h1 && !SLEEP_O;
  assign fl_ld = PRESET_I.flags_load;
  // only an executed subtract may write flags back, so compares and skips are caught here
  assign sub_q4 = PHASE_O == 4'h8 && ins_r[15:10] == SUB_BORROW_OPC && !SKIPPING_O;
  // the taken word is held so later phases can be tied back to it
  always_comb begin
    ins_nxt = take ? INSTR_I : ins_r;
    bsr_nxt = take ? BANK_SELECT_REG_I : bsr_r;
  end
  always_ff @(posedge MCLK_I) begin
    ins_r <= ins_nxt;
    bsr_r <= bsr_nxt;
  end
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  // ==========================================================================
  // steps
  sequence sub_go;
    take && INSTR_I[15:10] == SUB_BORROW_OPC ##1 FILE_REQ_O.rd;
  endsequence
  sequence slp_go;
    take && INSTR_I == SLEEP_WORD ##1 !SKIPPING_O;
  endsequence
  // ==========================================================================
  // properties
  chk_phase_step: assert property (
    take |=> PHASE_O == 4'h2 ##1 PHASE_O == 4'h4 ##1 PHASE_O == 4'h8 ##1 PHASE_O == 4'h1)
    else $error("phase order broken");
  chk_read_q2: assert property (
    FILE_REQ_O.rd |-> PHASE_O == 4'h2 && !SKIPPING_O) else $error("read outside Q2");
  chk_sub_dest: assert property (
    sub_go |-> ##2 FILE_REQ_O.wr == ins_r[DEST_BIT]) else $error("wrong destination");
  chk_bank_addr: assert property (
    sub_go ##0 ins_r[ACCESS_BIT] |-> FILE_REQ_O.addr == {bsr_r, ins_r[7:0]})
    else $error("bank address wrong");
  chk_sleep_entry: assert property (
    slp_go |-> ##3 WATCHDOG_CLEAR_O && SLEEP_O && TIMEOUT_FLAG_O && !POWER_DOWN_FLAG_O)
    else $error("sleep entry wrong");
  chk_wdog_pulse: assert property (
    WATCHDOG_CLEAR_O |=> !WATCHDOG_CLEAR_O) else $error("watchdog clear too long");
  chk_sleep_halt: assert property (
    SLEEP_O && !WAKE_I |=> SLEEP_O && PHASE_O == 4'h1 && !FILE_REQ_O.rd)
    else $error("core ran while halted");
  chk_skip_len: assert property (
    $rose(SKIPPING_O) |-> SKIPPING_O[*4]) else $error("skip cut short");
  chk_flags_hold: assert property (
    $changed(FLAGS_O) |-> $past(fl_ld) || $past(sub_q4))
    else $error("flags moved outside write-back");
endmodule : cssse_exec_sva
bind cssse_exec cssse_exec_sva u_sva (
  .MCLK_I(MCLK_I),
  .RST_N_I(RST_N_I),
  .WAKE_I(WAKE_I),
  .INSTR_I(INSTR_I),
  .BANK_SELECT_REG_I(BANK_SELECT_REG_I),
  .PRESET_I(PRESET_I),
  .FILE_REQ_O(FILE_REQ_O),
  .PHASE_O(PHASE_O),
  .SKIPPING_O(SKIPPING_O),
  .FLAGS_O(FLAGS_O),
  .TIMEOUT_FLAG_O(TIMEOUT_FLAG_O),
  .POWER_DOWN_FLAG_O(POWER_DOWN_FLAG_O),
  .WATCHDOG_CLEAR_O(WATCHDOG_CLEAR_O),
  .SLEEP_O(SLEEP_O)
);

// ### verif/tb_top.sv
// self-checking bench for the execution unit
`timescale 1ns/1ns
module tb_top;
  import cssse_pkg::*;
  logic clk = 0, rst_n = 0, wake = 0, cin, s, skip, to, pd, wdc, slp;
  logic [15:0] instr = 16'hffff, w;
  logic [15:0] hd [4] = '{16'hc000, 16'hec00, 16'hee00, 16'hef00};
  logic [3:0] bank_select_reg = 4'h0, phase;
  logic [7:0] rdata = 8'h00, acc, a, f;
  logic [12:0] r;
  cssse_preset_s preset = '0;
  cssse_file_req_s req;
  cssse_flags_s flags;
  int err_count = 0, n_tests = 0, seed = 32'he582, i, k;
  cssse_exec u_dut (.MCLK_I(clk), .RST_N_I(rst_n), .INSTR_I(instr), .WAKE_I(wake),
    .BANK_SELECT_REG_I(bank_select_reg), .PRESET_I(preset), .FILE_REQ_O(req), .FILE_RDATA_I(rdata),
    .PHASE_O(phase), .SKIPPING_O(skip), .WORKING_ACCUMULATOR_O(acc), .FLAGS_O(flags),
    .TIMEOUT_FLAG_O(to), .POWER_DOWN_FLAG_O(pd), .WATCHDOG_CLEAR_O(wdc), .SLEEP_O(slp));
  initial forever #20 clk = ~clk;
  // ==========================================================================
  // helpers
  task cmp(string n, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : cmp
  // flags {n,ov,z,dc,c} over the result; c set means no borrow
  function automatic logic [12:0] exp_sub(logic [7:0] x, logic [7:0] y, logic c);
    logic [8:0] t;
    logic [4:0] h;
    t = {1'h0, x} + {1'h0, ~y} + 9'(c);
    h = {1'h0, x[3:0]} + {1'h0, ~y[3:0]} + 5'(c);
    return {t[7], x[7] != y[7] && t[7] != x[7], t[7:0] == 8'h00, h[4], t[8], t[7:0]};
  endfunction : exp_sub
  function automatic logic [11:0] exp_addr(logic [15:0] v, logic [3:0] b);
    if (v[ACCESS_BIT]) return {b, v[7:0]};
    return {v[7:0] < ACCESS_SPLIT ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, v[7:0]};
  endfunction : exp_addr
  // preset lands at the end of Q3 so an earlier write-back cannot overwrite it
  task go(logic [15:0] v, logic [7:0] d, logic pl, logic [7:0] pa, logic pc);
    @(negedge clk);
    for (k = 0; k < 40 && phase !== 4'h4; k++) @(negedge clk);
    preset = {pl, pa, pl, 4'h0, pc};
    @(negedge clk);
    preset = '0;
    @(negedge clk);
    instr = v;
    rdata = d;
    @(negedge clk);
    instr = 16'hffff;
  endtask : go
  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // ==========================================================================
  // tests
  initial begin
    repeat (6) @(negedge clk);
    cmp("reset", {4'h1, 8'h00, 4'hc}, {phase, acc, to, pd, slp, req.rd});
    rst_n = 1;
    for (i = 0; i < 24; i++) begin
      {a, f, cin, bank_select_reg} = 21'($random(seed));
      w = {SUB_BORROW_OPC, 10'($random(seed))};
      if (i == 0) {a, f, cin} = {8'h02, 8'h03, 1'h1};
      if (i == 1) {a, f, cin} = {8'h05, 8'h02, 1'h1};
      if (i == 2) {a, f, cin} = {8'h02, 8'h01, 1'h0};
      if (i == 3) w[8:0] = 9'h05f;
      if (i == 4) w[8:0] = 9'h060;
      r = exp_sub(a, f, cin);
      go(w, f, 1'h1, a, cin);
      cmp("read", {4'h1, exp_addr(w, bank_select_reg)}, {3'h0, req.rd, req.addr});
      repeat (2) @(negedge clk);
      cmp("wr", w[DEST_BIT], req.wr);
      if (w[DEST_BIT]) cmp("wdata", r[7:0], req.wdata);
      @(negedge clk);
      cmp("acc", {r[12:8], w[DEST_BIT] ? a : r[7:0]}, {flags, acc});
    end
    $display("subtract test done");
    // 24 rounds so that every two-word head is skipped at least once
    for (i = 0; i < 24; i++) begin
      a = {1'h0, 7'($random(seed))} + 8'h01;
      f = i % 3 == 0 ? a - 8'h01 : i % 3 == 1 ? a : a + 8'h01;
      s = i[0] ? f > a : f < a;
      cin = 1'($random(seed));
      go({i[0] ? CMP_GT_OPC : CMP_LT_OPC, 9'($random(seed))}, f, 1'h1, a, cin);
      cmp("cmp read", 1'h1, req.rd);
      if (i > 5) begin
        go(hd[i % 4], 8'h00, 1'h0, 8'h00, 1'h0);
        cmp("skip head", s, skip);
      end
      go({SUB_BORROW_OPC, 10'h200}, 8'h00, 1'h0, 8'h00, 1'h0);
      cmp("skip next", {s, !s, 4'h0, cin}, {skip, req.rd, flags});
      @(negedge clk);
    end
    $display("compare test done");
    go(SLEEP_WORD, 8'h00, 1'h0, 8'h00, 1'h0);
    repeat (3) @(negedge clk);
    cmp("sleep", 4'he, {wdc, slp, to, pd});
    repeat (5) @(negedge clk);
    cmp("halt", 6'h11, {wdc, slp, phase});
    wake = 1;
    @(negedge clk);
    wake = 0;
    cmp("wake", 1'h0, slp);
    go({SUB_BORROW_OPC, 10'h000}, 8'h00, 1'h0, 8'h00, 1'h0);
    cmp("resume", 1'h1, req.rd);
    $display("sleep test done");
    conclude;
  end
  initial begin
    #400000;
    err_count++;
    conclude;
  end
endmodule : tb_top
